// *** design/cal_status_pkg.sv ***
// Shared constants for the calibration status register groups
package cal_status_pkg;

  // ********************************************
  // Register geometry
  // ********************************************
  localparam int REG_W = 16;
  localparam logic [15:0] FILTER_MASK        = 16'h7fff;
  localparam logic [15:0] PROGRESS_USED_MASK = 16'h0007;
  localparam logic [15:0] PROGRESS_LIVE_MASK = 16'h0007;
  localparam logic [15:0] FAULT_USED_MASK    = 16'h01ff;
  localparam logic [15:0] FAULT_LIVE_MASK    = 16'h000f;

  // ********************************************
  // Reset values
  // ********************************************
  localparam logic [15:0] RISE_RESET   = 16'hffff;
  localparam logic [15:0] FALL_RESET   = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] EVENT_RESET  = 16'h0000;

  // ********************************************
  // Bit positions
  // ********************************************
  localparam int PROG_ZEROING_BIT  = 0;
  localparam int PROG_CHPOWER_BIT  = 1;
  localparam int PROG_BASEBAND_BIT = 2;
  localparam int FAULT_SPECAN_BIT  = 0;
  localparam int FAULT_SAMPLER_BIT = 1;
  localparam int FAULT_COUNTER_BIT = 2;
  localparam int FAULT_VOLTMTR_BIT = 3;
  localparam int FAULT_TXZERO_BIT  = 4;
  localparam int FAULT_DIGZERO_BIT = 5;
  localparam int FAULT_CHCAL_BIT   = 6;
  localparam int FAULT_PORT_BIT    = 7;
  localparam int FAULT_PCB_BIT     = 8;
  localparam int STB_FAULT_BIT     = 3;
  localparam int STB_W             = 8;

  // ********************************************
  // Pin counts
  // ********************************************
  localparam int NUM_CAL_PINS      = 3;
  localparam int NUM_SELFCAL_PINS  = 4;
  localparam int NUM_FAULT_PULSES  = 5;
  localparam int NUM_SYNC          = NUM_CAL_PINS + NUM_SELFCAL_PINS;

  // ********************************************
  // Command encoding
  // ********************************************
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_CLEAR = 2'h2;
  localparam logic [1:0] OP_RESET = 2'h3;
  localparam logic       GRP_PROGRESS = 1'b0;
  localparam logic       GRP_FAULT    = 1'b1;
  localparam logic [2:0] REG_COND   = 3'h0;
  localparam logic [2:0] REG_RISE   = 3'h1;
  localparam logic [2:0] REG_FALL   = 3'h2;
  localparam logic [2:0] REG_EVENT  = 3'h3;
  localparam logic [2:0] REG_ENABLE = 3'h4;

  typedef enum logic [0:0] {ST_IDLE, ST_HOLD} cmd_state_e;

endpackage

// *** design/cal_status_top.sv ***
// Calibration progress and calibration fault status groups with command port
`timescale 1ns/100ps
module cal_status_top
  import cal_status_pkg::*;
(
  input  wire logic                        mclk,
  input  wire logic                        reset,
  input  wire logic [NUM_CAL_PINS-1:0]     calPins,
  input  wire logic [NUM_SELFCAL_PINS-1:0] selfCalPins,
  input  wire logic [NUM_FAULT_PULSES-1:0] faultEvents,
  input  wire logic                        cmdValid,
  input  wire logic [1:0]                  cmdOp,
  input  wire logic                        cmdGroup,
  input  wire logic [2:0]                  cmdReg,
  input  wire logic [REG_W-1:0]            cmdData,
  input  wire logic                        operEnableCal,
  input  wire logic                        questEnableCal,
  output logic                             cmdReady,
  output logic                             rspValid,
  output logic [REG_W-1:0]                 rspData,
  output logic                             rspError,
  output logic                             calBusy,
  output logic                             progressSummary,
  output logic                             faultSummary,
  output logic                             operCalReport,
  output logic [STB_W-1:0]                 statusByteBits
);

  // ********************************************
  // Pin synchronisers
  // ********************************************
  logic [NUM_SYNC-1:0] sync1_q;
  logic [NUM_SYNC-1:0] sync2_q;
  logic [NUM_SYNC-1:0] sync3_q;
  logic [NUM_SYNC-1:0] stable_q;
  logic [NUM_SYNC-1:0] stable_d;
  wire  [NUM_SYNC-1:0] differ;

  // Only stages two and three vote; stage one feeds stage two alone
  assign differ   = sync2_q ^ sync3_q;
  assign stable_d = (~differ & sync2_q) | (differ & stable_q);

  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_q  <= '0;
      sync2_q  <= '0;
      sync3_q  <= '0;
      stable_q <= '0;
    end else begin
      sync1_q  <= {selfCalPins, calPins};
      sync2_q  <= sync1_q;
      sync3_q  <= sync2_q;
      stable_q <= stable_d;
    end
  end

  // ********************************************
  // Group instances
  // ********************************************
  group_if progIf ();
  group_if faultIf ();

  wire [NUM_CAL_PINS-1:0]     progPins;
  wire [NUM_SELFCAL_PINS-1:0] selfPins;

  assign progPins = stable_q[NUM_CAL_PINS-1:0];
  assign selfPins = stable_q[NUM_SYNC-1:NUM_CAL_PINS];

  // Baseband, channel power and zeroing activity on bits 2..0
  assign progIf.cond    = REG_W'(progPins);
  assign progIf.evPulse = '0;
  // Self-calibration failures on live bits 3..0
  assign faultIf.cond   = REG_W'(selfPins);
  // Failure pulses without a condition land on bits 8..4
  assign faultIf.evPulse = REG_W'(faultEvents) << FAULT_TXZERO_BIT;

  status_group #(
    .USED_MASK (PROGRESS_USED_MASK),
    .LIVE_MASK (PROGRESS_LIVE_MASK)
  ) progGroup (
    .mclk  (mclk),
    .reset (reset),
    .bus   (progIf)
  );

  status_group #(
    .USED_MASK (FAULT_USED_MASK),
    .LIVE_MASK (FAULT_LIVE_MASK)
  ) faultGroup (
    .mclk  (mclk),
    .reset (reset),
    .bus   (faultIf)
  );

  // ********************************************
  // Command holding and deferral
  // ********************************************
  cmd_state_e       state_q;
  cmd_state_e       state_d;
  logic             ready_q;
  logic [1:0]       op_q;
  logic             grp_q;
  logic [2:0]       reg_q;
  logic [REG_W-1:0] data_q;
  wire              take;
  wire              calActive;
  wire              exec;

  // Either the synced pin or the sampled condition still shows activity
  assign calActive = (|progPins) | (|progIf.condReg);
  assign take      = cmdValid & ready_q;
  // Held command runs only once every calibration has ended
  assign exec      = (state_q == ST_HOLD) & ~calActive;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (exec) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      ready_q <= 1'b0;
      op_q    <= OP_READ;
      grp_q   <= GRP_PROGRESS;
      reg_q   <= REG_COND;
      data_q  <= '0;
    end else begin
      state_q <= state_d;
      ready_q <= (state_d == ST_IDLE);
      if (take) begin
        op_q   <= cmdOp;
        grp_q  <= cmdGroup;
        reg_q  <= cmdReg;
        data_q <= cmdData;
      end
    end
  end

  // ********************************************
  // Command decode
  // ********************************************
  wire isRead;
  wire isWrite;
  wire isClear;
  wire isReset;
  wire selProg;
  wire selFault;
  wire regKnown;
  wire regWritable;

  assign isRead      = exec & (op_q == OP_READ);
  assign isWrite     = exec & (op_q == OP_WRITE);
  assign isClear     = exec & (op_q == OP_CLEAR);
  assign isReset     = exec & (op_q == OP_RESET);
  assign selProg     = (grp_q == GRP_PROGRESS);
  assign selFault    = (grp_q == GRP_FAULT);
  assign regKnown    = (reg_q <= REG_ENABLE);
  assign regWritable = (reg_q == REG_RISE) | (reg_q == REG_FALL) |
                       (reg_q == REG_ENABLE);

  assign progIf.wrData  = data_q;
  assign faultIf.wrData = data_q;

  assign progIf.wrRise    = isWrite & selProg & (reg_q == REG_RISE);
  assign progIf.wrFall    = isWrite & selProg & (reg_q == REG_FALL);
  assign progIf.wrEnable  = isWrite & selProg & (reg_q == REG_ENABLE);
  assign faultIf.wrRise   = isWrite & selFault & (reg_q == REG_RISE);
  assign faultIf.wrFall   = isWrite & selFault & (reg_q == REG_FALL);
  assign faultIf.wrEnable = isWrite & selFault & (reg_q == REG_ENABLE);

  // Reading an event register empties it; clear-status empties both
  assign progIf.evClear  = (isRead & selProg & (reg_q == REG_EVENT)) |
                           isClear;
  assign faultIf.evClear = (isRead & selFault & (reg_q == REG_EVENT)) |
                           isClear;
  // Clear-status never touches the filters, only the reset command does
  assign progIf.filterReset  = isReset;
  assign faultIf.filterReset = isReset;

  // ********************************************
  // Read selection
  // ********************************************
  wire [REG_W-1:0] rdProg;
  wire [REG_W-1:0] rdFault;
  wire [REG_W-1:0] rdSel;
  wire             badCmd;

  assign rdProg  = (reg_q == REG_COND)   ? progIf.condReg   :
                   (reg_q == REG_RISE)   ? progIf.riseReg   :
                   (reg_q == REG_FALL)   ? progIf.fallReg   :
                   (reg_q == REG_EVENT)  ? progIf.eventReg  :
                   (reg_q == REG_ENABLE) ? progIf.enableReg : '0;
  assign rdFault = (reg_q == REG_COND)   ? faultIf.condReg   :
                   (reg_q == REG_RISE)   ? faultIf.riseReg   :
                   (reg_q == REG_FALL)   ? faultIf.fallReg   :
                   (reg_q == REG_EVENT)  ? faultIf.eventReg  :
                   (reg_q == REG_ENABLE) ? faultIf.enableReg : '0;
  // Masking again keeps bit 15 clear whatever the group holds
  assign rdSel   = (selProg ? rdProg : rdFault) & FILTER_MASK;
  // Writes to read-only or unknown registers are dropped and flagged
  assign badCmd  = (op_q == OP_READ & ~regKnown) |
                   (op_q == OP_WRITE & ~regWritable);

  // ********************************************
  // Answers and parent summaries
  // ********************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      rspValid        <= 1'b0;
      rspData         <= '0;
      rspError        <= 1'b0;
      calBusy         <= 1'b0;
      progressSummary <= 1'b0;
      faultSummary    <= 1'b0;
      operCalReport   <= 1'b0;
      statusByteBits  <= '0;
    end else begin
      rspValid        <= exec;
      rspData         <= isRead ? rdSel : '0;
      rspError        <= exec & badCmd;
      calBusy         <= calActive;
      progressSummary <= progIf.summary;
      faultSummary    <= faultIf.summary;
      operCalReport   <= progIf.summary & operEnableCal;
      statusByteBits  <= STB_W'(faultIf.summary & questEnableCal) <<
                         STB_FAULT_BIT;
    end
  end

  assign cmdReady = ready_q;

endmodule

// *** design/group_if.sv ***
// Connection between the command logic and one status register group
`timescale 1ns/100ps
interface group_if;
  import cal_status_pkg::*;
  logic [REG_W-1:0] cond;
  logic [REG_W-1:0] evPulse;
  logic [REG_W-1:0] wrData;
  logic             wrRise;
  logic             wrFall;
  logic             wrEnable;
  logic             evClear;
  logic             filterReset;
  logic [REG_W-1:0] condReg;
  logic [REG_W-1:0] riseReg;
  logic [REG_W-1:0] fallReg;
  logic [REG_W-1:0] eventReg;
  logic [REG_W-1:0] enableReg;
  logic             summary;

  modport grp (
    input  cond, evPulse, wrData, wrRise, wrFall, wrEnable, evClear,
           filterReset,
    output condReg, riseReg, fallReg, eventReg, enableReg, summary
  );
  modport ctl (
    output cond, evPulse, wrData, wrRise, wrFall, wrEnable, evClear,
           filterReset,
    input  condReg, riseReg, fallReg, eventReg, enableReg, summary
  );
endinterface

// *** design/status_group.sv ***
// One status register group: condition, filters, event, enable, summary
`timescale 1ns/100ps
module status_group
  import cal_status_pkg::*;
#(
  parameter logic [REG_W-1:0] USED_MASK = PROGRESS_USED_MASK,
  parameter logic [REG_W-1:0] LIVE_MASK = PROGRESS_LIVE_MASK
) (
  input wire logic mclk,
  input wire logic reset,
  group_if.grp     bus
);

  // ********************************************
  // Edge filtering
  // ********************************************
  logic [REG_W-1:0] cond_q;
  logic [REG_W-1:0] rise_q;
  logic [REG_W-1:0] fall_q;
  logic [REG_W-1:0] event_q;
  logic [REG_W-1:0] enable_q;
  logic [REG_W-1:0] cond_d;
  logic [REG_W-1:0] rise_d;
  logic [REG_W-1:0] fall_d;
  logic [REG_W-1:0] event_d;
  logic [REG_W-1:0] enable_d;
  wire  [REG_W-1:0] rising;
  wire  [REG_W-1:0] falling;
  wire  [REG_W-1:0] direct;
  wire  [REG_W-1:0] setBits;

  // Bits without a live condition stay zero here
  assign cond_d  = bus.cond & LIVE_MASK & USED_MASK & FILTER_MASK;
  assign rising  = cond_d & ~cond_q & rise_q;
  assign falling = ~cond_d & cond_q & fall_q;
  // Non-live bits are raised straight from their event pulse
  assign direct  = bus.evPulse & ~LIVE_MASK;
  assign setBits = (rising | falling | direct) & USED_MASK & FILTER_MASK;
  // Set beats clear so an event in the read cycle survives
  assign event_d = (bus.evClear ? EVENT_RESET : event_q) | setBits;

  assign rise_d = bus.filterReset ? (RISE_RESET & FILTER_MASK) :
                  bus.wrRise ? (bus.wrData & FILTER_MASK) : rise_q;
  assign fall_d = bus.filterReset ? FALL_RESET :
                  bus.wrFall ? (bus.wrData & FILTER_MASK) : fall_q;
  // Unused enable bits are dropped on write
  assign enable_d = bus.wrEnable ? (bus.wrData & USED_MASK & FILTER_MASK) :
                    enable_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      cond_q   <= '0;
      rise_q   <= RISE_RESET & FILTER_MASK;
      fall_q   <= FALL_RESET;
      event_q  <= EVENT_RESET;
      enable_q <= ENABLE_RESET;
    end else begin
      cond_q   <= cond_d;
      rise_q   <= rise_d;
      fall_q   <= fall_d;
      event_q  <= event_d;
      enable_q <= enable_d;
    end
  end

  // ********************************************
  // Read back and summary
  // ********************************************
  assign bus.condReg   = cond_q;
  assign bus.riseReg   = rise_q;
  assign bus.fallReg   = fall_q;
  assign bus.eventReg  = event_q;
  assign bus.enableReg = enable_q;
  assign bus.summary   = |(event_q & enable_q);

endmodule

// *** test/cal_status_sva.sv ***
// Port-level assertions for the calibration status groups
`timescale 1ns/100ps
module cal_status_sva
  import cal_status_pkg::*;
(
  input wire logic                    mclk,
  input wire logic                    reset,
  input wire logic [NUM_CAL_PINS-1:0] calPins,
  input wire logic                    cmdValid,
  input wire logic [1:0]              cmdOp,
  input wire logic                    cmdGroup,
  input wire logic [2:0]              cmdReg,
  input wire logic                    operEnableCal,
  input wire logic                    questEnableCal,
  input wire logic                    cmdReady,
  input wire logic                    rspValid,
  input wire logic [REG_W-1:0]        rspData,
  input wire logic                    calBusy,
  input wire logic                    progressSummary,
  input wire logic                    faultSummary,
  input wire logic                    operCalReport,
  input wire logic [STB_W-1:0]        statusByteBits
);
  logic [1:0] lastOp_q;
  logic       lastGrp_q;
  logic [2:0] lastReg_q;
  logic [2:0] quiet_q;
  logic       take;
  logic       isRead;
  assign take   = cmdValid && cmdReady;
  assign isRead = rspValid && lastOp_q == OP_READ;

  // Cycles since the last calibration pin activity, saturating
  always_ff @(posedge mclk) begin
    if (reset || calPins != 3'h0) begin
      quiet_q <= 3'h0;
    end else if (quiet_q != 3'h7) begin
      quiet_q <= quiet_q + 3'h1;
    end
  end
  // Remembers which command the next answer belongs to
  always_ff @(posedge mclk) begin
    if (take) begin
      lastOp_q  <= cmdOp;
      lastGrp_q <= cmdGroup;
      lastReg_q <= cmdReg;
    end
  end

  // ********************************************
  // Assertions
  // ********************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  stb_bit_only_a: assert property (
    statusByteBits[7:4] == 4'h0 && statusByteBits[2:0] == 3'h0)
    else $error("status byte bit other than three set");
  stb_gate_a: assert property (
    statusByteBits[STB_FAULT_BIT] |->
      $past(questEnableCal) && ($past(faultSummary) || faultSummary))
    else $error("fault report without parent enable");
  oper_gate_a: assert property (
    operCalReport |->
      $past(operEnableCal) && ($past(progressSummary) || progressSummary))
    else $error("progress report without parent enable");
  rsp_bit15_a: assert property (
    rspValid |-> !rspData[15])
    else $error("bit 15 read as one");
  cond_idle_a: assert property (
    isRead && lastGrp_q == GRP_PROGRESS && lastReg_q == REG_COND
      |-> rspData == 16'h0000)
    else $error("progress condition read shows activity");
  prog_unused_a: assert property (
    isRead && lastGrp_q == GRP_PROGRESS && lastReg_q >= REG_EVENT
      |-> rspData[15:3] == 13'h0000)
    else $error("unused progress bit read as one");
  fault_unused_a: assert property (
    isRead && lastGrp_q == GRP_FAULT && lastReg_q >= REG_EVENT
      |-> rspData[15:9] == 7'h00)
    else $error("unused fault bit read as one");
  quick_answer_a: assert property (
    take && !calBusy && quiet_q == 3'h7 |=> !cmdReady ##1 rspValid)
    else $error("idle command not answered in two cycles");
  busy_mute_a: assert property (
    calBusy |-> !rspValid)
    else $error("answer given during calibration");
endmodule

// *** test/gpib_ctl_model.sv ***
// Remote controller model driving the command port
`timescale 1ns/100ps
module gpib_ctl_model
  import cal_status_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             cmdReady,
  input  wire logic             rspValid,
  input  wire logic [REG_W-1:0] rspData,
  input  wire logic             rspError,
  output logic                  cmdValid,
  output logic [1:0]            cmdOp,
  output logic                  cmdGroup,
  output logic [2:0]            cmdReg,
  output logic [REG_W-1:0]      cmdData
);
  initial begin
    cmdValid = 1'b0;
    cmdOp    = 2'h0;
    cmdGroup = 1'b0;
    cmdReg   = 3'h0;
    cmdData  = 16'h0000;
  end

  // Called just after a rising edge; returns just after one
  task automatic cmd(input logic [1:0] op, input logic grp,
                     input logic [2:0] rg, input logic [REG_W-1:0] d,
                     output logic [REG_W-1:0] rd, output logic err);
    while (cmdReady !== 1'b1) begin
      @(posedge mclk);
      #1;
    end
    cmdValid = 1'b1;
    cmdOp    = op;
    cmdGroup = grp;
    cmdReg   = rg;
    cmdData  = d;
    @(posedge mclk);
    #1;
    // Released op and data lines show garbage; group and register lines keep the old command
    cmdValid = 1'b0;
    cmdOp    = ~op;
    cmdData  = ~d;
    do begin
      @(posedge mclk);
      #1;
    end while (rspValid !== 1'b1);
    rd  = rspData;
    err = rspError;
  endtask
endmodule

// *** test/tb_cal_status_top.sv ***
// Self-checking bench for the calibration status groups
`timescale 1ns/100ps
module tb_cal_status_top
  import cal_status_pkg::*;;
  logic        mclk, reset, cmdValid, cmdGroup, operEnableCal;
  logic        questEnableCal, cmdReady, rspValid, rspError, calBusy;
  logic        progressSummary, faultSummary, operCalReport;
  logic [2:0]  calPins, cmdReg;
  logic [3:0]  selfCalPins;
  logic [4:0]  faultEvents;
  logic [1:0]  cmdOp;
  logic [15:0] cmdData, rspData;
  logic [7:0]  statusByteBits;
  int          fails, checks, cycles;

  cal_status_top cal_status_top_inst (.mclk(mclk), .reset(reset),
    .calPins(calPins), .selfCalPins(selfCalPins),
    .faultEvents(faultEvents), .cmdValid(cmdValid), .cmdOp(cmdOp),
    .cmdGroup(cmdGroup), .cmdReg(cmdReg), .cmdData(cmdData),
    .operEnableCal(operEnableCal), .questEnableCal(questEnableCal),
    .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData),
    .rspError(rspError), .calBusy(calBusy),
    .progressSummary(progressSummary), .faultSummary(faultSummary),
    .operCalReport(operCalReport), .statusByteBits(statusByteBits));
  gpib_ctl_model gpib_ctl_model_inst (.mclk(mclk), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData), .rspError(rspError),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdGroup(cmdGroup),
    .cmdReg(cmdReg), .cmdData(cmdData));

  task automatic tally_and_finish();
    if (fails == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic op(input logic [1:0] o, input logic g, input logic [2:0] r,
                    input logic [15:0] v, input logic [15:0] exp,
                    input logic ee);
    logic [15:0] d;
    logic        e;
    gpib_ctl_model_inst.cmd(o, g, r, v, d, e);
    chk(d, exp);
    chk({15'h0, e}, {15'h0, ee});
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Run should need well under a thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    {reset, calPins, selfCalPins, faultEvents} = {1'b1, 12'h000};
    {operEnableCal, questEnableCal} = 2'b00;
    tick(2);
    reset = 1'b0;
    tick(1);
    for (int g = 0; g < 2; g++) begin
      op(OP_READ, g[0], REG_RISE, 16'h0, 16'h7fff, 1'b0);
      op(OP_READ, g[0], REG_FALL, 16'h0, 16'h0000, 1'b0);
      op(OP_READ, g[0], REG_EVENT, 16'h0, 16'h0000, 1'b0);
      op(OP_READ, g[0], REG_ENABLE, 16'h0, 16'h0000, 1'b0);
      op(OP_WRITE, g[0], REG_COND, 16'h7, 16'h0000, 1'b1);
      op(OP_READ, g[0], REG_COND, 16'h0, 16'h0000, 1'b0);
      op(OP_READ, g[0], 3'h5, 16'h0, 16'h0000, 1'b1);
      for (int r = 1; r < 5; r++) begin
        if (r != 3) op(OP_WRITE, g[0], 3'(r), 16'hfff5, 16'h0, 1'b0);
      end
      op(OP_READ, g[0], REG_RISE, 16'h0, 16'h7ff5, 1'b0);
      op(OP_READ, g[0], REG_FALL, 16'h0, 16'h7ff5, 1'b0);
      op(OP_READ, g[0], REG_ENABLE, 16'h0,
         g ? 16'h01f5 : 16'h0005, 1'b0);
    end
    op(OP_WRITE, GRP_FAULT, REG_ENABLE, 16'hffff, 16'h0, 1'b0);
    questEnableCal = 1'b1;
    for (int k = 0; k < 5; k++) begin
      repeat (2) begin
        faultEvents = 5'(1 << k);
        tick(1);
        faultEvents = 5'h00;
        tick(1);
      end
      tick(2);
      chk({15'h0, faultSummary}, 16'h0001);
      chk({8'h0, statusByteBits}, 16'h0008);
      op(OP_READ, GRP_FAULT, REG_EVENT, 16'h0,
         16'(16'h10 << k), 1'b0);
      op(OP_READ, GRP_FAULT, REG_EVENT, 16'h0, 16'h0000, 1'b0);
    end
    selfCalPins = 4'h5;
    tick(8);
    op(OP_READ, GRP_FAULT, REG_COND, 16'h0, 16'h0005, 1'b0);
    op(OP_READ, GRP_FAULT, REG_EVENT, 16'h0, 16'h0005, 1'b0);
    selfCalPins = 4'h0;
    questEnableCal = 1'b0;
    tick(8);
    chk({15'h0, faultSummary}, 16'h0001);
    chk({8'h0, statusByteBits}, 16'h0000);
    op(OP_READ, GRP_FAULT, REG_EVENT, 16'h0, 16'h0005, 1'b0);
    faultEvents = 5'h01;
    tick(1);
    faultEvents = 5'h00;
    tick(2);
    op(OP_CLEAR, GRP_FAULT, REG_EVENT, 16'h0, 16'h0000, 1'b0);
    op(OP_READ, GRP_FAULT, REG_EVENT, 16'h0, 16'h0000, 1'b0);
    op(OP_READ, GRP_FAULT, REG_RISE, 16'h0, 16'h7ff5, 1'b0);
    op(OP_RESET, GRP_FAULT, REG_RISE, 16'h0, 16'h0000, 1'b0);
    op(OP_READ, GRP_FAULT, REG_RISE, 16'h0, 16'h7fff, 1'b0);
    op(OP_READ, GRP_FAULT, REG_FALL, 16'h0, 16'h0000, 1'b0);
    op(OP_READ, GRP_FAULT, REG_ENABLE, 16'h0, 16'h01ff, 1'b0);
    op(OP_WRITE, GRP_PROGRESS, REG_RISE, 16'h7, 16'h0, 1'b0);
    op(OP_WRITE, GRP_PROGRESS, REG_ENABLE, 16'h7, 16'h0, 1'b0);
    for (int b = 0; b < 3; b++) begin
      operEnableCal = (b != 1);
      fork
        begin
          calPins = 3'(1 << b);
          tick(30);
          calPins = 3'h0;
        end
        begin
          tick(8);
          chk({15'h0, calBusy}, 16'h0001);
          op(OP_READ, GRP_PROGRESS, REG_COND, 16'h0, 16'h0000, 1'b0);
        end
      join
      chk({15'h0, operCalReport}, {15'h0, operEnableCal});
      op(OP_READ, GRP_PROGRESS, REG_EVENT, 16'h0,
         16'(1 << b), 1'b0);
      tick(3);
      chk({15'h0, progressSummary}, 16'h0000);
    end
    tally_and_finish();
  end
endmodule

bind cal_status_top cal_status_sva cal_status_sva_inst (.mclk(mclk),
  .reset(reset), .calPins(calPins), .cmdValid(cmdValid), .cmdOp(cmdOp),
  .cmdGroup(cmdGroup), .cmdReg(cmdReg), .operEnableCal(operEnableCal),
  .questEnableCal(questEnableCal), .cmdReady(cmdReady),
  .rspValid(rspValid), .rspData(rspData), .calBusy(calBusy),
  .progressSummary(progressSummary), .faultSummary(faultSummary),
  .operCalReport(operCalReport), .statusByteBits(statusByteBits));
